/* hw/vla_params.svh */
// Constants for the vector length and load/store access block
`ifndef VLA_PARAMS_SVH
`define VLA_PARAMS_SVH
`define VLA_LEN_W        4
`define VLA_LEN_ZERO     4'h0
`define VLA_LEN_FULL     4'hf
`define VLA_CHUNK_BITS   128
`define VLA_NUM_LEVELS   3
`define VLA_IDX_W        9
`define VLA_VREG_MASK    64'h000000000000000f
`define VLA_PREG_MASK    64'h0000000000000001
`define VLA_SP_MASK      64'h000000000000000f
`define VLA_VREG_BYTES   9'h010
`define VLA_PREG_BYTES   9'h002
`define VLA_BYTE_SIZE    2'h0
`define VLA_BYTE_MASK    64'h00000000000000ff
`endif

/* hw/vla_pkg.sv */
// Types shared by the vector length and load/store access block
package vla_pkg;
`include "vla_params.svh"

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_WAIT = 3'b100
    } vla_state_e;

    typedef enum logic [1:0] {
        KIND_ELEM = 2'h0,
        KIND_VREG = 2'h1,
        KIND_PREG = 2'h2
    } vla_kind_e;

    typedef struct packed {
        vla_state_e            state;
        logic [3:0]            eff_len;
        logic [15:0]           acc_mask;
        logic [15:0]           grow_zero;
        logic                  preserve;
        vla_kind_e             kind;
        logic                  store;
        logic                  chk;
        logic                  big_end;
        logic                  sgn;
        logic [1:0]            msize;
        logic [1:0]            esize;
        logic [63:0]           base;
        logic [8:0]            idx;
        logic [8:0]            count;
        logic                  req_ready;
        logic                  mem_req;
        logic                  mem_we;
        logic [63:0]           mem_addr;
        logic [1:0]            mem_size;
        logic                  mem_atomic;
        logic [63:0]           mem_wdata;
        logic                  ld_valid;
        logic [63:0]           ld_data;
        logic                  fault;
        logic                  done;
    } vla_state_s;
endpackage

/* hw/vla_top.sv */
// Effective vector length and vector load/store element sequencer
`timescale 1ns/100ps
module vla_top
    import vla_pkg::*;
#(
    parameter logic [3:0]  MAX_LEN  = 4'hf,
    parameter logic [15:0] SUP_MASK = 16'h808b
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [1:0]  cur_level,
    input  wire logic [3:0]  length_limit_field_el1,
    input  wire logic [3:0]  length_limit_field_el2,
    input  wire logic [3:0]  length_limit_field_el3,
    input  wire logic [3:0]  level_vec_off,
    input  wire logic        lower_levels_off,
    input  wire logic        zero_on_grow,
    input  wire logic        alignment_check_bit,
    input  wire logic        sp_align_check,
    input  wire logic        big_endian,
    input  wire logic        req_valid,
    input  wire logic [1:0]  req_kind,
    input  wire logic        req_store,
    input  wire logic        req_device,
    input  wire logic        req_sp_base,
    input  wire logic        req_signed,
    input  wire logic [1:0]  req_msize,
    input  wire logic [1:0]  req_esize,
    input  wire logic [8:0]  req_nelem,
    input  wire logic [63:0] req_addr,
    input  wire logic        elem_active,
    input  wire logic [63:0] st_data,
    input  wire logic        mem_ack,
    input  wire logic [63:0] mem_rdata,
    output logic [3:0]       eff_len,
    output logic [15:0]      acc_mask,
    output logic [15:0]      grow_zero,
    output logic             preserve_state,
    output logic             req_ready,
    output logic [8:0]       elem_idx,
    output logic             mem_req,
    output logic             mem_we,
    output logic [63:0]      mem_addr,
    output logic [1:0]       mem_size,
    output logic             mem_atomic,
    output logic [63:0]      mem_wdata,
    output logic             ld_valid,
    output logic [63:0]      ld_data,
    output logic             align_fault,
    output logic             req_done
);
`include "vla_params.svh"

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Low address bits that must be zero for a size of 1 << sz bytes
    function automatic logic [63:0] size_mask(input logic [1:0] sz);
        size_mask = (64'h1 << sz) - 64'h1;
    endfunction

    // Keep only the low 1 << sz bytes
    function automatic logic [63:0] trunc(input logic [63:0] d,
                                          input logic [1:0]  sz);
        logic [63:0] m;
        m     = (sz == 2'h3) ? ~64'h0 : ((64'h1 << (8 << sz)) - 64'h1);
        trunc = d & m;
    endfunction

    // Reverse the bytes inside a 1 << sz byte item
    function automatic logic [63:0] bswap(input logic [63:0] d,
                                          input logic [1:0]  sz);
        int n;
        bswap = 64'h0;
        n     = 1 << sz;
        for (int i = 0; i < 8; i++) begin
            if (i < n) begin
                bswap[i*8 +: 8] = d[(n - 1 - i)*8 +: 8];
            end
        end
    endfunction

    // Sign or zero extend from memory size, then clip to element size
    function automatic logic [63:0] extend(input logic [63:0] d,
                                           input logic [1:0]  msz,
                                           input logic [1:0]  esz,
                                           input logic        sgn);
        logic [63:0] m;
        logic        top;
        m      = trunc(~64'h0, msz);
        top    = d[(8 << msz) - 1];
        extend = (d & m) | ((sgn && top) ? ~m : 64'h0);
        extend = trunc(extend, esz);
    endfunction

    // One bit per accessible 128-bit chunk
    function automatic logic [15:0] chunks(input logic [3:0] len);
        chunks = 16'((17'h2 << len) - 17'h1);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    vla_state_s state_reg;
    vla_state_s state_next;

    logic [3:0]  field_eff [1:`VLA_NUM_LEVELS];
    logic [3:0]  cap;
    logic [3:0]  len_sel;
    logic [63:0] el_addr;
    logic        el_mis;
    logic        base_bad;
    logic        chk_now;
    logic [8:0]  cnt_now;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        state_next           = state_reg;
        state_next.ld_valid  = 1'b0;
        state_next.fault     = 1'b0;
        state_next.done      = 1'b0;
        state_next.grow_zero = 16'h0;

        // Disabled, trapped or 32-bit levels behave as field zero
        field_eff[1] = level_vec_off[1] ? `VLA_LEN_ZERO
                                        : length_limit_field_el1;
        field_eff[2] = level_vec_off[2] ? `VLA_LEN_ZERO
                                        : length_limit_field_el2;
        field_eff[3] = level_vec_off[3] ? `VLA_LEN_ZERO
                                        : length_limit_field_el3;

        // Tightest cap of the current level and all above it
        cap = MAX_LEN;
        for (int l = 1; l <= `VLA_NUM_LEVELS; l++) begin
            if (l >= int'(cur_level) && field_eff[l] < cap) begin
                cap = field_eff[l];
            end
        end

        // Largest supported length not above the cap; fields untouched
        len_sel = `VLA_LEN_ZERO;
        for (int i = 0; i <= int'(`VLA_LEN_FULL); i++) begin
            if (4'(i) <= cap && SUP_MASK[i]) begin
                len_sel = 4'(i);
            end
        end
        // Visible the cycle after the field changes, no barrier needed
        state_next.eff_len  = len_sel;
        state_next.acc_mask = chunks(len_sel);
        if (len_sel > state_reg.eff_len && zero_on_grow) begin
            state_next.grow_zero = chunks(len_sel)
                                 & ~chunks(state_reg.eff_len);
        end
        state_next.preserve = lower_levels_off;

        // Checks for the request offered in this cycle
        chk_now  = alignment_check_bit | req_device;
        base_bad = 1'b0;
        if (chk_now && req_kind == KIND_VREG) begin
            base_bad = |(req_addr & `VLA_VREG_MASK);
        end
        if (chk_now && req_kind == KIND_PREG) begin
            base_bad = |(req_addr & `VLA_PREG_MASK);
        end
        if (req_sp_base && sp_align_check &&
            |(req_addr & `VLA_SP_MASK)) begin
            base_bad = 1'b1;
        end
        unique case (req_kind)
            KIND_VREG: cnt_now = `VLA_VREG_BYTES
                               * (9'(state_reg.eff_len) + 9'h1);
            KIND_PREG: cnt_now = `VLA_PREG_BYTES
                               * (9'(state_reg.eff_len) + 9'h1);
            default:   cnt_now = req_nelem;
        endcase

        // Address of the current element
        if (state_reg.kind == KIND_ELEM) begin
            el_addr = state_reg.base
                    + (64'(state_reg.idx) << state_reg.msize);
        end else begin
            el_addr = state_reg.base + 64'(state_reg.idx);
        end
        el_mis = |(el_addr & size_mask(state_reg.msize));

        // Element sequencer
        unique case (state_reg.state)
            ST_IDLE: begin
                if (req_valid && state_reg.req_ready) begin
                    state_next.kind    = vla_kind_e'(req_kind);
                    state_next.store   = req_store;
                    state_next.chk     = chk_now;
                    state_next.big_end = big_endian;
                    state_next.sgn     = req_signed;
                    state_next.msize   = (req_kind == KIND_ELEM)
                                       ? req_msize : `VLA_BYTE_SIZE;
                    state_next.esize   = req_esize;
                    state_next.base    = req_addr;
                    state_next.idx     = 9'h0;
                    state_next.count   = cnt_now;
                    if (base_bad) begin
                        state_next.fault = 1'b1;
                        state_next.done  = 1'b1;
                    end else if (cnt_now == 9'h0) begin
                        state_next.done = 1'b1;
                    end else begin
                        state_next.state     = ST_RUN;
                        state_next.req_ready = 1'b0;
                    end
                end
            end
            ST_RUN: begin
                if (state_reg.idx == state_reg.count) begin
                    state_next.done      = 1'b1;
                    state_next.state     = ST_IDLE;
                    state_next.req_ready = 1'b1;
                end else if (state_reg.kind == KIND_ELEM && !elem_active) begin
                    state_next.idx = state_reg.idx + 9'h1;
                end else if (state_reg.kind == KIND_ELEM &&
                             state_reg.chk && el_mis) begin
                    state_next.fault     = 1'b1;
                    state_next.done      = 1'b1;
                    state_next.state     = ST_IDLE;
                    state_next.req_ready = 1'b1;
                end else begin
                    state_next.mem_req  = 1'b1;
                    state_next.mem_we   = state_reg.store;
                    state_next.mem_addr = el_addr;
                    state_next.mem_size = state_reg.msize;
                    // Single access; atomic when aligned or one byte
                    state_next.mem_atomic = !el_mis;
                    if (state_reg.kind != KIND_ELEM) begin
                        state_next.mem_wdata = st_data
                                             & `VLA_BYTE_MASK;
                    end else if (state_reg.big_end) begin
                        state_next.mem_wdata = bswap(trunc(st_data,
                            state_reg.msize), state_reg.msize);
                    end else begin
                        state_next.mem_wdata = trunc(st_data,
                                                     state_reg.msize);
                    end
                    state_next.state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (mem_ack) begin
                    state_next.mem_req = 1'b0;
                    state_next.idx     = state_reg.idx + 9'h1;
                    state_next.state   = ST_RUN;
                    if (!state_reg.store) begin
                        state_next.ld_valid = 1'b1;
                        if (state_reg.kind != KIND_ELEM) begin
                            state_next.ld_data = mem_rdata
                                               & `VLA_BYTE_MASK;
                        end else if (state_reg.big_end) begin
                            state_next.ld_data = extend(bswap(mem_rdata,
                                state_reg.msize), state_reg.msize,
                                state_reg.esize, state_reg.sgn);
                        end else begin
                            state_next.ld_data = extend(mem_rdata,
                                state_reg.msize, state_reg.esize,
                                state_reg.sgn);
                        end
                    end
                end
            end
            default: begin
                state_next.state     = ST_IDLE;
                state_next.req_ready = 1'b1;
                state_next.mem_req   = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg           <= '0;
            state_reg.state     <= ST_IDLE;
            state_reg.kind      <= KIND_ELEM;
            state_reg.req_ready <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign eff_len        = state_reg.eff_len;
    assign acc_mask       = state_reg.acc_mask;
    assign grow_zero      = state_reg.grow_zero;
    assign preserve_state = state_reg.preserve;
    assign req_ready      = state_reg.req_ready;
    assign elem_idx       = state_reg.idx;
    assign mem_req        = state_reg.mem_req;
    assign mem_we         = state_reg.mem_we;
    assign mem_addr       = state_reg.mem_addr;
    assign mem_size       = state_reg.mem_size;
    assign mem_atomic     = state_reg.mem_atomic;
    assign mem_wdata      = state_reg.mem_wdata;
    assign ld_valid       = state_reg.ld_valid;
    assign ld_data        = state_reg.ld_data;
    assign align_fault    = state_reg.fault;
    assign req_done       = state_reg.done;

endmodule // vla_top

/* test/vla_checker.sv */
// Port assertions for the vector length and load/store block
`timescale 1ns/100ps
module vla_checker
    import vla_pkg::*;
#(
    parameter logic [3:0]  MAX_LEN  = 4'hf,
    parameter logic [15:0] SUP_MASK = 16'h808b
) (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        lower_levels_off,
    input wire logic        alignment_check_bit,
    input wire logic        sp_align_check,
    input wire logic        req_valid,
    input wire logic [1:0]  req_kind,
    input wire logic        req_device,
    input wire logic        req_sp_base,
    input wire logic [63:0] req_addr,
    input wire logic        mem_ack,
    input wire logic [3:0]  eff_len,
    input wire logic [15:0] acc_mask,
    input wire logic [15:0] grow_zero,
    input wire logic        preserve_state,
    input wire logic        req_ready,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [63:0] mem_addr,
    input wire logic [1:0]  mem_size,
    input wire logic        mem_atomic,
    input wire logic        ld_valid,
    input wire logic        align_fault,
    input wire logic        req_done
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////
    // Accepted request whose base address fails a check
    sequence s_base_bad;
        req_valid && req_ready && ((req_sp_base && sp_align_check
            && req_addr[3:0] != 4'h0) || ((alignment_check_bit || req_device)
            && ((req_kind == 2'h1 && req_addr[3:0] != 4'h0)
            || (req_kind == 2'h2 && req_addr[0]))));
    endsequence
    // Read completed by the memory side
    sequence s_read_ack;
        mem_req && mem_ack && !mem_we;
    endsequence
    chk_busy_ready: assert property (mem_req |-> !req_ready)
        else $error("ready high during access");
    chk_req_hold: assert property (mem_req && !mem_ack |=>
        mem_req && $stable(mem_addr) && $stable(mem_size))
        else $error("access dropped before ack");
    chk_load_return: assert property (s_read_ack |=> ld_valid)
        else $error("no load data after ack");
    chk_done_ready: assert property (req_done |-> req_ready)
        else $error("done without ready");
    chk_atomic_align: assert property (mem_req |->
        mem_atomic == ((mem_addr & ((64'h1 << mem_size) - 64'h1)) == 64'h0))
        else $error("atomic flag wrong");
    chk_fault_nomem: assert property (align_fault |->
        req_done && !mem_req)
        else $error("fault with access");
    chk_base_fault: assert property (s_base_bad |=>
        align_fault && req_done)
        else $error("base fault missed");
    chk_len_mask: assert property (!$past(reset) |->
        acc_mask == 16'((32'h2 << eff_len) - 32'h1))
        else $error("mask does not match length");
    chk_len_support: assert property (
        SUP_MASK[eff_len] && eff_len <= MAX_LEN)
        else $error("unsupported length");
    chk_grow_new: assert property (grow_zero != 16'h0 |->
        (grow_zero & ($past(acc_mask) | ~acc_mask)) == 16'h0)
        else $error("zeroed chunk not regained");
    chk_keep_state: assert property (!$stable(lower_levels_off) |=>
        preserve_state == $past(lower_levels_off))
        else $error("preserve flag late");
endmodule // vla_checker

bind vla_top vla_checker #(.MAX_LEN(MAX_LEN), .SUP_MASK(SUP_MASK)) u_chk (
    .clk_sys, .reset, .lower_levels_off, .alignment_check_bit,
    .sp_align_check, .req_valid, .req_kind, .req_device, .req_sp_base,
    .req_addr, .mem_ack, .eff_len, .acc_mask, .grow_zero, .preserve_state,
    .req_ready, .mem_req, .mem_we, .mem_addr, .mem_size, .mem_atomic,
    .ld_valid, .align_fault, .req_done
);

/* test/vla_mem_model.sv */
// Memory-side responder for element accesses
`timescale 1ns/100ps
module vla_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic [63:0] mem_addr,
    output logic             mem_ack,
    output logic [63:0]      mem_rdata
);
    logic [1:0] wait_cnt;
    ////////////////////////////////////////////////////////////////////
    // Ack at once or after three cycles; data is garbage outside the ack
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mem_ack   <= 1'b0;
            wait_cnt  <= 2'h0;
            mem_rdata <= 64'h5aa5c33c0ff0a55a;
        end else if (mem_ack || !mem_req || (slow && wait_cnt != 2'h3)) begin
            mem_ack   <= 1'b0;
            wait_cnt  <= mem_req && !mem_ack ? wait_cnt + 2'h1 : 2'h0;
            mem_rdata <= ~mem_rdata;  // Idle bus toggles
        end else begin
            mem_ack   <= 1'b1;
            mem_rdata <= {8{mem_addr[7:0]}} ^ 64'h0123456789abcdef;
        end
    end
endmodule // vla_mem_model

/* test/vla_top_tb_top.sv */
// Self-checking bench for the vector length and load/store block
`timescale 1ns/100ps
module vla_top_tb_top
    import vla_pkg::*;
;
    typedef struct {
        logic        we;
        logic        at;
        logic [1:0]  sz;
        logic [63:0] a;
        logic [63:0] d;
        logic [63:0] m;
    } vla_acc_s;
    localparam logic [15:0] SUP_MASK = 16'h808b;
    logic         clk_sys, reset, lower_levels_off, zero_on_grow, slow;
    logic         alignment_check_bit, sp_align_check, big_endian, req_valid;
    logic         req_store, req_device, req_sp_base, req_signed, elem_active;
    logic         mem_ack, preserve_state, req_ready, mem_req, mem_we;
    logic         mem_atomic, ld_valid, align_fault, req_done;
    logic [1:0]   cur_level, req_kind, req_msize, req_esize, mem_size;
    logic [3:0]   length_limit_field_el1, length_limit_field_el2;
    logic [3:0]   length_limit_field_el3, level_vec_off, eff_len;
    logic [8:0]   req_nelem, elem_idx;
    logic [15:0]  acc_mask, grow_zero, om, nm;
    logic [63:0]  req_addr, st_data, mem_rdata, mem_addr, mem_wdata, ld_data;
    logic [511:0] pred;
    vla_acc_s     aq[$], me;
    logic [63:0]  lq[$];
    int           n_fail, samples_checked, n_flt;

    vla_top #(.MAX_LEN(4'hf), .SUP_MASK(SUP_MASK)) DUT (
        .clk_sys, .reset, .cur_level, .length_limit_field_el1,
        .length_limit_field_el2, .length_limit_field_el3, .level_vec_off,
        .lower_levels_off, .zero_on_grow, .alignment_check_bit,
        .sp_align_check, .big_endian, .req_valid, .req_kind, .req_store,
        .req_device, .req_sp_base, .req_signed, .req_msize, .req_esize,
        .req_nelem, .req_addr, .elem_active, .st_data, .mem_ack, .mem_rdata,
        .eff_len, .acc_mask, .grow_zero, .preserve_state, .req_ready,
        .elem_idx, .mem_req, .mem_we, .mem_addr, .mem_size, .mem_atomic,
        .mem_wdata, .ld_valid, .ld_data, .align_fault, .req_done);
    vla_mem_model u_mem (.clk_sys, .reset, .slow, .mem_req, .mem_addr,
        .mem_ack, .mem_rdata);
    ////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        #600000;
        n_fail++;
        summarize();
    end
    // Comparison, byte helpers and the length model
    task automatic check(input logic [63:0] seen, exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t %s seen %h exp %h", $time, what,
                     seen, exp);
        end
    endtask
    function automatic logic [63:0] msk(input int n);
        return n == 8 ? '1 : (64'h1 << (8 * n)) - 64'h1;
    endfunction
    function automatic logic [63:0] swp(input logic [63:0] v, input int n);
        logic [63:0] r;
        r = 64'h0;
        for (int j = 0; j < n; j++) r[8*j+:8] = v[8*(n-1-j)+:8];
        return r;
    endfunction
    function automatic logic [63:0] sdat(input logic [8:0] i);
        return 64'h9e3779b97f4a7c15 * ({55'h0, i} + 64'h1);
    endfunction
    function automatic logic [3:0] len_exp();
        logic [3:0] c, f [3];
        c = 4'hf;
        f = '{length_limit_field_el1, length_limit_field_el2,
              length_limit_field_el3};
        for (int l = 1; l < 4; l++)
            if (l >= int'(cur_level) && level_vec_off[l]) c = 4'h0;
            else if (l >= int'(cur_level) && f[l-1] < c) c = f[l-1];
        while (!SUP_MASK[c]) c--;
        return c;
    endfunction
    // Present predicate and store data for the element in progress
    always @(negedge clk_sys) begin
        elem_active <= pred[elem_idx];
        st_data     <= sdat(elem_idx);
    end
    // Compare memory traffic and load returns with the queued model
    always @(negedge clk_sys) begin
        if (mem_req && mem_ack) begin
            me = aq.size() > 0 ? aq.pop_front() : '{default: 'x};
            check(mem_addr, me.a, "addr");
            check(mem_size, me.sz, "size");
            check(mem_atomic, me.at, "atomic");
            check(mem_we, me.we, "dir");
            if (me.we) check(mem_wdata & me.m, me.d, "wdata");
        end
        if (ld_valid)
            check(ld_data, lq.size() ? lq.pop_front() : 'x, "ld");
        if (align_fault) n_flt++;
    end
    // One request, with its expected accesses worked out first
    task automatic op(input logic [1:0] k, input logic [8:0] n,
                      input logic [63:0] a);
        vla_acc_s    e;
        logic        chk, bad;
        logic [63:0] v;
        int          nb, sz, t;
        chk = alignment_check_bit | req_device;
        nb = k == KIND_ELEM ? int'(n) : (k == KIND_VREG ? 16 : 2)
             * (int'(len_exp()) + 1);
        sz = k == KIND_ELEM ? 1 << req_msize : 1;
        bad = (req_sp_base && sp_align_check && a[3:0] != 4'h0)
            || (chk && k == KIND_VREG && a[3:0] != 4'h0)
            || (chk && k == KIND_PREG && a[0]);
        for (int i = 0; i < nb && !bad; i++) begin
            if (k == KIND_ELEM && !pred[i]) continue;
            e.a = a + 64'(i * sz);
            e.sz = k == KIND_ELEM ? req_msize : 2'h0;
            e.at = (e.a & 64'(sz - 1)) == 64'h0;
            if (chk && !e.at) begin
                bad = 1'b1;
                break;
            end
            e.we = req_store;
            e.m = msk(sz);
            v = sdat(9'(i));
            e.d = big_endian && k == KIND_ELEM ? swp(v, sz) : v & e.m;
            aq.push_back(e);
            if (!req_store) begin
                v = {8{e.a[7:0]}} ^ 64'h0123456789abcdef;
                v = big_endian && k == KIND_ELEM ? swp(v, sz) : v & e.m;
                if (req_signed && k == KIND_ELEM && v[8*sz-1]) v = v | ~e.m;
                lq.push_back(k == KIND_ELEM ? v & msk(1 << req_esize) : v);
            end
        end
        n_flt = 0;
        req_kind = k;
        req_nelem = n;
        req_addr = a;
        req_valid = 1'b1;
        while (req_ready !== 1'b1) @(negedge clk_sys);
        @(negedge clk_sys);
        req_valid = 1'b0;
        for (t = 0; t < 3000 && req_done !== 1'b1; t++) @(negedge clk_sys);
        @(posedge clk_sys) #1;
        check(t < 3000, 1'b1, "done");
        check(n_flt, bad, "fault");
        check(aq.size() + lq.size(), 0, "left");
        aq.delete();
        lq.delete();
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {reset, slow, lower_levels_off, zero_on_grow, alignment_check_bit,
         sp_align_check, big_endian, req_valid, req_store, req_device,
         req_sp_base, req_signed, elem_active} = 13'h1000;
        {cur_level, req_kind, req_msize, req_esize, level_vec_off} = '0;
        {length_limit_field_el1, length_limit_field_el2} = '0;
        {length_limit_field_el3, req_nelem, req_addr, st_data, pred} = '0;
        void'($urandom(5998));
        @(negedge clk_sys);
        check({req_ready, mem_req, req_done, align_fault}, 4'h8, "reset");
        @(negedge clk_sys);
        reset = 1'b0;
        om = 16'h1;
        repeat (2) @(negedge clk_sys);
        // Length limits at random levels and fields
        for (int i = 0; i < 40; i++) begin
            {cur_level, zero_on_grow, lower_levels_off} = 4'($urandom);
            level_vec_off = 4'($urandom) & 4'($urandom);
            {length_limit_field_el1, length_limit_field_el2,
             length_limit_field_el3} = 12'($urandom);
            nm = 16'((32'h2 << len_exp()) - 32'h1);
            @(negedge clk_sys);
            check(eff_len, len_exp(), "len");
            check(acc_mask, nm, "mask");
            check(grow_zero, zero_on_grow ? nm & ~om : 16'h0, "grow");
            check(preserve_state, lower_levels_off, "keep");
            @(negedge clk_sys);
            check(grow_zero, 16'h0, "pulse");
            om = nm;
        end
        {cur_level, level_vec_off, length_limit_field_el1} = 10'h001;
        {length_limit_field_el2, length_limit_field_el3} = 8'hff;
        // Inactive misaligned elements pass, the first active one faults
        {alignment_check_bit, req_msize, req_store, req_esize} = 6'h2a;
        pred = 512'hc;
        @(negedge clk_sys);
        op(KIND_ELEM, 9'h4, 64'h1001);
        // Random requests of every kind, address and memory speed
        for (int i = 0; i < 80; i++) begin
            if (i % 8 == 0) length_limit_field_el1 = 4'($urandom_range(0, 4));
            repeat (2) @(negedge clk_sys);
            {req_store, req_device, req_sp_base, req_signed, big_endian,
             alignment_check_bit, sp_align_check, slow} = 8'($urandom);
            req_msize = 2'($urandom);
            req_esize = req_msize | 2'($urandom);
            pred = {16{$urandom}};
            op(2'($urandom_range(0, 2)), 9'($urandom_range(0, 6)),
               {32'($urandom), 28'($urandom), 4'(i % 2 ? $urandom : 0)});
        end
        summarize();
    end
endmodule // vla_top_tb_top
